// File: hdl/ssq_stack_regs.sv
/*
 * Register bank of four sequencer stack slots with a plain register
 * port and a sequencer walk that presents the current channel pair.
 * Assumes: single clock mclk, strobes one cycle long, never together.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssq_defs.svh"

module ssq_stack_regs
    import ssq_pkg::*;
#(
    parameter int NUM_SLOTS = `SSQ_NUM_SLOTS
)
(
    input  wire logic           mclk,
    input  wire logic           rst_b,
    input  wire ssq_pkg::ssq_addr_t reg_addr,
    input  wire ssq_pkg::ssq_word_t reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output ssq_pkg::ssq_word_t  reg_rdata,
    input  wire logic           seq_enable,
    input  wire logic           conv_start,
    input  wire logic           conv_done,
    output ssq_pkg::ssq_chan_t  conv_a_chan,
    output ssq_pkg::ssq_chan_t  conv_b_chan
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    localparam ssq_addr_t SLOT_OFF [4] = '{`SSQ_OFF_SLOT_19, `SSQ_OFF_SLOT_20,
                                           `SSQ_OFF_SLOT_21, `SSQ_OFF_SLOT_22};
    localparam ssq_word_t SLOT_RST [4] = '{`SSQ_RST_SLOT_19, `SSQ_RST_SLOT_20,
                                           `SSQ_RST_SLOT_21, `SSQ_RST_SLOT_22};

    function automatic logic [3:0] slot_hit(input ssq_addr_t a);
        logic [3:0] h;
        h = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            h[i] = (a == SLOT_OFF[i]);
        end
        return h;
    endfunction

    logic [3:0] wr_hit;
    logic [3:0] rd_hit;
    assign wr_hit = reg_wr ? slot_hit(reg_addr) : 4'h0;
    assign rd_hit = slot_hit(reg_addr);

    ////////////////////////////////////////////////////////////////////////
    // Slots

    ssq_word_t            slot_val [4];
    ssq_chan_t            slot_cha [4];
    ssq_chan_t            slot_chb [4];
    logic [NUM_SLOTS-1:0] ret_flags;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_slot
            ssq_slot #(
                .RESET_VAL (SLOT_RST[g])
            ) u_slot (
                .mclk        (mclk),
                .rst_b       (rst_b),
                .wr_en       (wr_hit[g]),
                .wdata       (reg_wdata),
                .return_flag (ret_flags[g]),
                .chan_a      (slot_cha[g]),
                .chan_b      (slot_chb[g]),
                .value       (slot_val[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Sequencer walk

    ssq_idx_t slot_idx;
    logic     busy;

    ssq_walker #(
        .NUM_SLOTS (NUM_SLOTS)
    ) u_walker (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .seq_enable (seq_enable),
        .conv_start (conv_start),
        .conv_done  (conv_done),
        .ret_flags  (ret_flags),
        .slot_idx   (slot_idx),
        .busy       (busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // State: read data and the latched channel pair

    typedef struct packed {
        ssq_word_t rdata;
        ssq_chan_t cha;
        ssq_chan_t chb;
    } ssq_top_state_t;

    ssq_top_state_t st_q;
    ssq_top_state_t st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.rdata = '0;
        if (reg_rd)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (rd_hit[i])
                begin
                    st_d.rdata = slot_val[i];
                end
            end
            if (reg_addr == `SSQ_OFF_STATUS)
            begin
                st_d.rdata = {13'h0000, busy, slot_idx};
            end
        end
        // Channel codes latched at conversion start, raw encoding
        // A start while disabled is refused, as in the walker
        if (conv_start && !busy && seq_enable)
        begin
            st_d.cha = slot_cha[slot_idx];
            st_d.chb = slot_chb[slot_idx];
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q.rdata <= '0;
            st_q.cha   <= '0;
            st_q.chb   <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign reg_rdata   = st_q.rdata;
    assign conv_a_chan = st_q.cha;
    assign conv_b_chan = st_q.chb;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_rd_status;
        @(posedge mclk) disable iff (!rst_b)
        reg_rd && (reg_addr == `SSQ_OFF_STATUS)
            |=> (reg_rdata == {13'h0000, $past(busy), $past(slot_idx)});
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read wrong");

    property p_rd_slot20;
        @(posedge mclk) disable iff (!rst_b)
        reg_rd && (reg_addr == `SSQ_OFF_SLOT_20) |=> (reg_rdata == $past(slot_val[1]));
    endproperty
    a_rd_slot20: assert property (p_rd_slot20) else $error("slot 0x34 read wrong");

    property p_rd_slot21;
        @(posedge mclk) disable iff (!rst_b)
        reg_rd && (reg_addr == `SSQ_OFF_SLOT_21) |=> (reg_rdata == $past(slot_val[2]));
    endproperty
    a_rd_slot21: assert property (p_rd_slot21) else $error("slot 0x35 read wrong");

    property p_rd_unmapped;
        @(posedge mclk) disable iff (!rst_b)
        reg_rd && (slot_hit(reg_addr) == 4'h0) && (reg_addr != `SSQ_OFF_STATUS)
            |=> (reg_rdata == 16'h0000);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_wr_slot19;
        @(posedge mclk) disable iff (!rst_b)
        reg_wr && (reg_addr == `SSQ_OFF_SLOT_19) |=> (slot_val[0] == $past(reg_wdata));
    endproperty
    a_wr_slot19: assert property (p_wr_slot19) else $error("slot 0x33 write lost");

    property p_wr_slot20;
        @(posedge mclk) disable iff (!rst_b)
        reg_wr && (reg_addr == `SSQ_OFF_SLOT_20) |=> (slot_val[1] == $past(reg_wdata));
    endproperty
    a_wr_slot20: assert property (p_wr_slot20) else $error("slot 0x34 word lost");

    property p_wr_slot21;
        @(posedge mclk) disable iff (!rst_b)
        reg_wr && (reg_addr == `SSQ_OFF_SLOT_21) |=> (slot_val[2] == $past(reg_wdata));
    endproperty
    a_wr_slot21: assert property (p_wr_slot21) else $error("slot 0x35 write lost");

    property p_wr_slot22;
        @(posedge mclk) disable iff (!rst_b)
        reg_wr && (reg_addr == `SSQ_OFF_SLOT_22) |=> (slot_val[3] == $past(reg_wdata));
    endproperty
    a_wr_slot22: assert property (p_wr_slot22) else $error("slot 0x36 write lost");

    property p_wr_other;
        @(posedge mclk) disable iff (!rst_b)
        reg_wr && (reg_addr != `SSQ_OFF_SLOT_19) |=> $stable(slot_val[0]);
    endproperty
    a_wr_other: assert property (p_wr_other) else $error("slot 0x33 hit by other write");

    property p_chan_a_field;
        @(posedge mclk) disable iff (!rst_b)
        conv_start && !busy && seq_enable
            |=> (conv_a_chan == $past(slot_val[slot_idx][`SSQ_CHA_HI:`SSQ_CHA_LO]));
    endproperty
    a_chan_a_field: assert property (p_chan_a_field) else $error("channel A field wrong");

    property p_chan_b_field;
        @(posedge mclk) disable iff (!rst_b)
        conv_start && !busy && seq_enable
            |=> (conv_b_chan == $past(slot_val[slot_idx][`SSQ_CHB_HI:`SSQ_CHB_LO]));
    endproperty
    a_chan_b_field: assert property (p_chan_b_field) else $error("channel B field wrong");

    property p_no_latch_off;
        @(posedge mclk) disable iff (!rst_b)
        conv_start && !seq_enable |=> $stable(conv_a_chan) && $stable(conv_b_chan);
    endproperty
    a_no_latch_off: assert property (p_no_latch_off) else $error("start taken while off");

    property p_busy_start;
        @(posedge mclk) disable iff (!rst_b)
        conv_start && seq_enable && !busy |=> busy;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("start not taken");

    property p_disable_index;
        @(posedge mclk) disable iff (!rst_b)
        !seq_enable && !busy |=> (slot_idx == 2'h0);
    endproperty
    a_disable_index: assert property (p_disable_index) else $error("index kept while off");

    property p_done_step;
        @(posedge mclk) disable iff (!rst_b)
        conv_done && busy |=> busy ##1 !busy;
    endproperty
    a_done_step: assert property (p_done_step) else $error("step after done wrong");

    property p_rd_slot19;
        @(posedge mclk) disable iff (!rst_b)
        reg_rd && (reg_addr == `SSQ_OFF_SLOT_19) |=> (reg_rdata == slot_val[0]);
    endproperty
    a_rd_slot19: assert property (p_rd_slot19) else $error("slot 0x33 read wrong");

    property p_rd_slot22;
        @(posedge mclk) disable iff (!rst_b)
        reg_rd && (reg_addr == `SSQ_OFF_SLOT_22) |=> (reg_rdata == slot_val[3]);
    endproperty
    a_rd_slot22: assert property (p_rd_slot22) else $error("slot 0x36 read wrong");

    property p_wr_read_back;
        @(posedge mclk) disable iff (!rst_b)
        reg_wr && (reg_addr == `SSQ_OFF_SLOT_20) ##1 reg_rd && (reg_addr == `SSQ_OFF_SLOT_20)
            |=> (reg_rdata == $past(reg_wdata, 2));
    endproperty
    a_wr_read_back: assert property (p_wr_read_back) else $error("slot 0x34 write lost");

    property p_rd_idle_zero;
        @(posedge mclk) disable iff (!rst_b)
        !reg_rd |=> (reg_rdata == 16'h0000);
    endproperty
    a_rd_idle_zero: assert property (p_rd_idle_zero) else $error("read data outside read");

    property p_chan_latch;
        @(posedge mclk) disable iff (!rst_b)
        conv_start && !busy && seq_enable |=> (conv_a_chan == $past(slot_cha[slot_idx]))
                                && (conv_b_chan == $past(slot_chb[slot_idx]));
    endproperty
    a_chan_latch: assert property (p_chan_latch) else $error("channel pair not latched");

    property p_chan_stable;
        @(posedge mclk) disable iff (!rst_b)
        busy |=> $stable(conv_a_chan) && $stable(conv_b_chan);
    endproperty
    a_chan_stable: assert property (p_chan_stable) else $error("channel changed mid conversion");

endmodule
`default_nettype wire

// File: hdl/ssq_defs.svh
/*
 * Offsets, field positions, reset values and widths of the four
 * channel-sequencer stack slots and the sequencer status word.
 * Assumes: included by bare name by the package and modules.
 */
`ifndef SSQ_DEFS_SVH
`define SSQ_DEFS_SVH

`define SSQ_ADDR_W          6
`define SSQ_DATA_W          16
`define SSQ_NUM_SLOTS       4
`define SSQ_OFF_SLOT_19     6'h33
`define SSQ_OFF_SLOT_20     6'h34
`define SSQ_OFF_SLOT_21     6'h35
`define SSQ_OFF_SLOT_22     6'h36
`define SSQ_OFF_STATUS      6'h3E
`define SSQ_RST_SLOT_19     16'h6600
`define SSQ_RST_SLOT_20     16'h6800
`define SSQ_RST_SLOT_21     16'h6A00
`define SSQ_RST_SLOT_22     16'h6C00
`define SSQ_BIT_ACCESS      15
`define SSQ_ADDR_HI         14
`define SSQ_ADDR_LO         9
`define SSQ_BIT_RETURN      8
`define SSQ_CHB_HI          7
`define SSQ_CHB_LO          4
`define SSQ_CHA_HI          3
`define SSQ_CHA_LO          0
`define SSQ_ACCESS_READ     1'h0
`define SSQ_ACCESS_WRITE    1'h1

`endif

// File: hdl/ssq_pkg.sv
/*
 * Types shared by the stack-slot register bank.
 * Assumes: ssq_defs.svh is on the include path.
 */
`include "ssq_defs.svh"

package ssq_pkg;

    typedef logic [`SSQ_DATA_W-1:0] ssq_word_t;
    typedef logic [`SSQ_ADDR_W-1:0] ssq_addr_t;
    typedef logic [3:0]             ssq_chan_t;
    typedef logic [1:0]             ssq_idx_t;

    // Sequencer walk states, one-hot
    typedef enum logic [2:0] {
        SSQ_IDLE = 3'b001,
        SSQ_CONV = 3'b010,
        SSQ_STEP = 3'b100
    } ssq_state_t;

endpackage

// File: hdl/ssq_slot.sv
/*
 * One 16-bit stack slot: holds access bit, address field, return flag
 * and the two channel fields, with its own reset value.
 * Assumes: write strobe already qualified by address decode.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssq_defs.svh"

module ssq_slot
    import ssq_pkg::*;
#(
    parameter logic [15:0] RESET_VAL = 16'h0000
)
(
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic         wr_en,
    input  wire ssq_pkg::ssq_word_t wdata,
    output logic              return_flag,
    output ssq_pkg::ssq_chan_t chan_a,
    output ssq_pkg::ssq_chan_t chan_b,
    output ssq_pkg::ssq_word_t value
);

    typedef struct packed {
        ssq_word_t word;
    } ssq_slot_state_t;

    ssq_slot_state_t st_q;
    ssq_slot_state_t st_d;

    always_comb
    begin
        st_d = st_q;
        if (wr_en)
        begin
            st_d.word = wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q.word <= RESET_VAL;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign value       = st_q.word;
    assign return_flag = st_q.word[`SSQ_BIT_RETURN];
    assign chan_b      = st_q.word[`SSQ_CHB_HI:`SSQ_CHB_LO];
    assign chan_a      = st_q.word[`SSQ_CHA_HI:`SSQ_CHA_LO];

    property p_slot_write;
        @(posedge mclk) disable iff (!rst_b)
        wr_en |=> (value == $past(wdata));
    endproperty
    a_slot_write: assert property (p_slot_write) else $error("slot write lost");

    property p_slot_hold;
        @(posedge mclk) disable iff (!rst_b)
        !wr_en |=> $stable(value);
    endproperty
    a_slot_hold: assert property (p_slot_hold) else $error("slot changed without write");

endmodule
`default_nettype wire

// File: hdl/ssq_walker.sv
/*
 * Sequencer walk over the slots: at each completed conversion it moves
 * to the next slot, or to the first when the return flag is set.
 * Assumes: conv_done is a one-cycle pulse from the converter timing.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssq_defs.svh"

module ssq_walker
    import ssq_pkg::*;
#(
    parameter int NUM_SLOTS = `SSQ_NUM_SLOTS
)
(
    input  wire logic            mclk,
    input  wire logic            rst_b,
    input  wire logic            seq_enable,
    input  wire logic            conv_start,
    input  wire logic            conv_done,
    input  wire logic [NUM_SLOTS-1:0] ret_flags,
    output ssq_pkg::ssq_idx_t    slot_idx,
    output logic                 busy
);

    typedef struct packed {
        ssq_state_t state;
        ssq_idx_t   idx;
    } ssq_walk_state_t;

    ssq_walk_state_t st_q;
    ssq_walk_state_t st_d;

    always_comb
    begin
        st_d = st_q;
        case (st_q.state)
            SSQ_IDLE:
            begin
                if (!seq_enable)
                begin
                    st_d.idx = '0;
                end
                else if (conv_start)
                begin
                    st_d.state = SSQ_CONV;
                end
            end
            SSQ_CONV:
            begin
                if (conv_done)
                begin
                    st_d.state = SSQ_STEP;
                end
            end
            SSQ_STEP:
            begin
                // Slot changes only once the conversion has finished
                if (ret_flags[st_q.idx] || (st_q.idx == ssq_idx_t'(NUM_SLOTS - 1)))
                begin
                    st_d.idx = '0;
                end
                else
                begin
                    st_d.idx = st_q.idx + 2'h1;
                end
                st_d.state = SSQ_IDLE;
            end
            default:
            begin
                st_d.state = SSQ_IDLE;
                st_d.idx   = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q.state <= SSQ_IDLE;
            st_q.idx   <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign slot_idx = st_q.idx;
    assign busy     = (st_q.state != SSQ_IDLE);

    property p_return_first;
        @(posedge mclk) disable iff (!rst_b)
        (st_q.state == SSQ_STEP) && ret_flags[st_q.idx] |=> (slot_idx == 2'h0);
    endproperty
    a_return_first: assert property (p_return_first) else $error("return flag ignored");

    property p_advance;
        @(posedge mclk) disable iff (!rst_b)
        (st_q.state == SSQ_STEP) && !ret_flags[st_q.idx] && (st_q.idx != 2'h3)
            |=> (slot_idx == $past(slot_idx) + 2'h1);
    endproperty
    a_advance: assert property (p_advance) else $error("slot did not advance");

    property p_no_mid_change;
        @(posedge mclk) disable iff (!rst_b)
        (st_q.state == SSQ_CONV) |=> $stable(slot_idx);
    endproperty
    a_no_mid_change: assert property (p_no_mid_change) else $error("slot changed mid conversion");

endmodule
`default_nettype wire

// File: verif/ssq_conv_model.sv
/*
 * Converter timing model: start pulse, conversion time, done pulse.
 * Assumes go is a one-cycle request from the bench while ready is high.
 */
`timescale 1ns/1ps
`default_nettype none

module ssq_conv_model
(
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       go,
    input  wire logic       dbl,
    input  wire logic [7:0] lat,
    output logic            conv_start,
    output logic            conv_done,
    output logic            ready
);
    logic [7:0] cnt_q;
    logic [1:0] ph_q;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {conv_start, conv_done, ready, cnt_q, ph_q} <= {3'h1, 8'h00, 2'h0};
        end
        else
        begin
            conv_start <= 1'b0;
            conv_done  <= 1'b0;
            case (ph_q)
                2'h0: if (go)
                begin
                    conv_start <= 1'b1;
                    ready      <= 1'b0;
                    cnt_q      <= lat;
                    ph_q       <= 2'h1;
                end
                2'h1:
                begin
                    // Optional second start while busy, which must be ignored
                    conv_start <= dbl && (cnt_q == lat);
                    cnt_q      <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00)
                    begin
                        conv_done <= 1'b1;
                        cnt_q     <= 8'h02;
                        ph_q      <= 2'h2;
                    end
                end
                default:
                begin
                    // Gap after done before the next start is allowed
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h00)
                    begin
                        ready <= 1'b1;
                        ph_q  <= 2'h0;
                    end
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// File: verif/ssq_stack_regs_tb_top.sv
/*
 * Bench for the stack-slot bank: reset values, read-back, refused
 * accesses and the sequencer walk.
 * Assumes the converter model drives conv_start and conv_done.
 */
`timescale 1ns/1ps
`default_nettype none

module ssq_stack_regs_tb_top;
    import ssq_pkg::*;
    logic       mclk;
    logic       rst_b;
    ssq_addr_t  reg_addr;
    ssq_word_t  reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    ssq_word_t  reg_rdata;
    logic       seq_enable;
    logic       conv_start;
    logic       conv_done;
    ssq_chan_t  conv_a_chan;
    ssq_chan_t  conv_b_chan;
    logic       go;
    logic       dbl;
    logic [7:0] lat;
    logic       ready;
    int         miscompares;
    int         check_count;
    logic       rd_pend;
    string      rd_what;
    ssq_word_t  rd_exp;
    ssq_addr_t  offs [4] = '{6'h33, 6'h34, 6'h35, 6'h36};
    ssq_word_t  rstv [4] = '{16'h6600, 16'h6800, 16'h6A00, 16'h6C00};
    ssq_word_t  pat  [4] = '{16'hFFFF, 16'h0000, 16'hA5A5, 16'h5A5A};

    ssq_stack_regs u_ssq_stack_regs (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .seq_enable(seq_enable), .conv_start(conv_start), .conv_done(conv_done),
        .conv_a_chan(conv_a_chan), .conv_b_chan(conv_b_chan));

    ssq_conv_model u_ssq_conv_model (.mclk(mclk), .rst_b(rst_b), .go(go), .dbl(dbl),
        .lat(lat), .conv_start(conv_start), .conv_done(conv_done), .ready(ready));

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input ssq_word_t seen, input ssq_word_t exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    function automatic ssq_word_t mk(input int i, input logic ret);
        mk = {1'b1, offs[i], ret, 4'hC - 4'(i), 4'h1 + 4'(i)};
    endfunction

    task automatic wr(input ssq_addr_t a, input ssq_word_t d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        @(posedge mclk);
    endtask

    // Read data are checked in the cycle after the strobe
    task automatic rd(input string what, input ssq_addr_t a, input ssq_word_t exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        @(posedge mclk);
        rd_what = what;
        rd_exp  = exp;
        rd_pend = 1'b1;
    endtask

    always @(negedge mclk)
    begin
        if (rd_pend)
        begin
            check(rd_what, reg_rdata, rd_exp);
            rd_pend = 1'b0;
        end
    end

    task automatic conv(input logic [7:0] l, input logic d, input int e);
        ssq_word_t w;
        int        n;
        w = mk(e, 1'b0);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        lat    <= l;
        dbl    <= d;
        go     <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        @(negedge mclk);
        for (n = 0; n < 100 && ready !== 1'b1; n++)
            @(negedge mclk);
        if (n >= 100)
            miscompares++;
        check("channels", {8'h00, conv_b_chan, conv_a_chan}, {8'h00, w[7:0]});
        @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        {rst_b, reg_wr, reg_rd, go, dbl} = 5'h00;
        seq_enable  = 1'b1;
        reg_addr    = 6'h00;
        reg_wdata   = 16'h0000;
        lat         = 8'h01;
        rd_pend     = 1'b0;
        miscompares = 0;
        check_count = 0;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 4; i++)
            rd("slot reset", offs[i], rstv[i]);
        $display("reset test done");
        for (int i = 0; i < 4; i++)
            wr(offs[i], pat[i]);
        wr(6'h3F, 16'hFFFF);
        wr(6'h3E, 16'hFFFF);
        for (int i = 0; i < 4; i++)
            rd("slot readback", offs[i], pat[i]);
        rd("unmapped", 6'h3F, 16'h0000);
        rd("below bank", 6'h32, 16'h0000);
        rd("status", 6'h3E, 16'h0000);
        $display("readback test done");
        for (int i = 0; i < 4; i++)
            wr(offs[i], mk(i, 1'b0));
        for (int i = 0; i < 5; i++)
            conv((i % 2) ? 8'h06 : 8'h01, 1'b0, i % 4);
        rd("status", 6'h3E, 16'h0001);
        wr(6'h35, mk(2, 1'b1));
        conv(8'h01, 1'b0, 1);
        conv(8'h06, 1'b0, 2);
        conv(8'h03, 1'b1, 0);
        conv(8'h01, 1'b0, 1);
        $display("walk test done");
        seq_enable <= 1'b0;
        conv(8'h01, 1'b0, 1);
        seq_enable <= 1'b1;
        conv(8'h01, 1'b0, 0);
        $display("enable test done");
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        check("channels reset", {8'h00, conv_b_chan, conv_a_chan}, 16'h0000);
        rst_b <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 4; i++)
            rd("slot reset again", offs[i], rstv[i]);
        rd("status reset", 6'h3E, 16'h0000);
        $display("second reset test done");
        wr(6'h3E, 16'h0000);
        reg_wr <= 1'b0;
        @(posedge mclk);
        @(posedge mclk);
        summarize();
    end

    initial
    begin
        repeat (3000) @(posedge mclk);
        miscompares++;
        summarize();
    end
endmodule

`default_nettype wire
